// ### rtl/pcmsp_pkg.sv
// Shared constants for the serial PCM port.
package pcmsp_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [4:0] LEN_LONG = 5'h10;
  localparam logic [4:0] LEN_SHORT = 5'h08;
  localparam logic [3:0] ADDR_BITS = 4'h8;
  localparam logic [3:0] STROBE_LAST = 4'hF;
  localparam logic [4:0] HALF_DIV4 = 5'h02;
  localparam logic [4:0] HALF_DIV12 = 5'h06;
  localparam logic [4:0] HALF_DIV16 = 5'h08;
  localparam logic [4:0] HALF_DIV20 = 5'h0A;
  localparam logic [1:0] RATE_DIV4 = 2'h0;
  localparam logic [1:0] RATE_DIV12 = 2'h1;
  localparam logic [1:0] RATE_DIV16 = 2'h2;
  localparam int FS_BIT_DIV8 = 2;
  localparam int FS_BIT_DIV16 = 3;
  localparam int LOAD_DELAY = 2;
  localparam logic EMPTY_RESET = 1'b1;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} pcmsp_tx_t;
endpackage : pcmsp_pkg

// ### rtl/pcmsp_clkdiv.sv
// Bit clock generator dividing the master clock by 4, 12, 16 or 20.
`timescale 1ns/1ps
`default_nettype none
module pcmsp_clkdiv (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Rate choice.
  input wire logic [1:0] rateSel,
  // Generated clock.
  output logic clkLevel,
  output logic risePulse
);
  logic [4:0] cnt;
  logic [4:0] half;

  always_comb
  begin
    if (rateSel == pcmsp_pkg::RATE_DIV4)
      half = pcmsp_pkg::HALF_DIV4;
    else if (rateSel == pcmsp_pkg::RATE_DIV12)
      half = pcmsp_pkg::HALF_DIV12;
    else if (rateSel == pcmsp_pkg::RATE_DIV16)
      half = pcmsp_pkg::HALF_DIV16;
    else
      half = pcmsp_pkg::HALF_DIV20;
  end

  // Each half period toggles the clock; a rise pulse marks the low-to-high change.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt <= 5'h00;
      clkLevel <= 1'b0;
      risePulse <= 1'b0;
    end
    else if (cnt >= half - 5'h01)
    begin
      cnt <= 5'h00;
      clkLevel <= ~clkLevel;
      risePulse <= ~clkLevel;
    end
    else
    begin
      cnt <= cnt + 5'h01;
      risePulse <= 1'b0;
    end
  end
endmodule : pcmsp_clkdiv
`default_nettype wire

// ### rtl/pcmsp_buf2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module pcmsp_buf2 (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Filling side.
  input wire logic [15:0] inData,
  input wire logic inValid,
  output logic inReady,
  // Draining side.
  output logic [15:0] outData,
  output logic outValid,
  input wire logic outReady
);
  logic [15:0] mem [0:1];
  logic wrPtr;
  logic rdPtr;
  logic [1:0] count;
  logic [1:0] next_count;
  logic doWrite;
  logic doRead;

  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = mem[rdPtr];

  always_comb
  begin
    next_count = count;
    if (doWrite && !doRead)
      next_count = count + 2'h1;
    else if (doRead && !doWrite)
      next_count = count - 2'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (doWrite)
      mem[wrPtr] <= inData;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
      outValid <= 1'b0;
      inReady <= 1'b1;
    end
    else
    begin
      wrPtr <= wrPtr ^ doWrite;
      rdPtr <= rdPtr ^ doRead;
      count <= next_count;
      outValid <= next_count != 2'h0;
      inReady <= next_count != pcmsp_pkg::BUF_DEPTH;
    end
  end
endmodule : pcmsp_buf2
`default_nettype wire

// ### rtl/pcmsp_port.sv
// Serial PCM port with input and output channels and a multiprocessor slot mode.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Input data is sampled on input clock rises in the chosen bit order.
// - Each bit clock is driven in active mode and received in passive mode.
// - A falling input strobe starts each input word.
// - The input strobe is driven in active mode and received in passive mode.
// - The full flag rises when a word is buffered and falls when the last buffered word is read.
// - Reset clears the full flag.
// - Output bits come from the shift register, changing on output clock rises.
// - Serial data output is driven only while the output enable is low.
// - In multiprocessor mode the device drives the output enable low in its slot.
// - A falling output strobe loads the shifter from the holding buffer.
// - The output strobe is driven in active mode and received in passive mode.
// - The empty flag sets when the shifter empties and on reset.
// - The empty flag clears when a word loads, two cycles after the strobe falls.
// - Without a new word the empty flag stays high across strobes.
// - The address line carries an eight-bit active-low stream.
// - In multiprocessor mode the address line is driven only in the own slot.
// - Otherwise the address line is an output, released while the enable is high.
// - A falling frame sync resynchronises both generated word strobes.
// - Frame sync is driven when enabled as output, received otherwise.
// - Driven frame sync runs at the strobe rate divided by eight or sixteen.
// - The active bit clock is the master clock divided by 4, 12, 16 or 20.
// - Both generated strobes count one common bit clock chosen by a select.
// - One select chooses most or least significant bit first.
// - Each length select gives sixteen bits when clear, eight when set.
module pcmsp_port (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration.
  input wire logic bitOrderSelect,
  input wire logic inLenSelect,
  input wire logic outLenSelect,
  input wire logic inClkActive,
  input wire logic outClkActive,
  input wire logic inStrobeActive,
  input wire logic outStrobeActive,
  input wire logic strobeSourceSel,
  input wire logic [1:0] clkRateSelect,
  input wire logic multiprocMode,
  input wire logic slotActive,
  input wire logic syncOutEnable,
  input wire logic syncRateSelect,
  input wire logic [7:0] serialAddrWord,
  // Software words.
  input wire logic [15:0] outWordData,
  input wire logic outWordValid,
  output logic outWordReady,
  output logic [15:0] inWordData,
  output logic inputBufferFullFlag,
  input wire logic inWordRead,
  output logic outputShifterEmpty,
  output logic inWordDropped,
  // Serial pins.
  input wire logic serialDataIn,
  input wire logic inBitClockIn,
  output logic inBitClockOut,
  output logic inBitClockOe,
  input wire logic inStrobeIn,
  output logic inStrobeOut,
  output logic inStrobeOe,
  input wire logic outBitClockIn,
  output logic outBitClockOut,
  output logic outBitClockOe,
  input wire logic outStrobeIn,
  output logic outStrobeOut,
  output logic outStrobeOe,
  output logic serialDataOut,
  output logic serialDataOutOe,
  input wire logic outEnableNIn,
  output logic outEnableNOut,
  output logic outEnableNOe,
  input wire logic serialAddrIn,
  output logic serialAddrOut,
  output logic serialAddrOe,
  input wire logic frameSyncIn,
  output logic frameSyncOut,
  output logic frameSyncOe
);
  localparam int P_DI = 0;
  localparam int P_ICK = 1;
  localparam int P_OCK = 2;
  localparam int P_ILD = 3;
  localparam int P_OLD = 4;
  localparam int P_FS = 5;
  localparam int P_OUTPUT_ENABLE_N = 6;

  logic [6:0] pinA;
  logic [6:0] pinB;
  logic [6:0] pinP;
  logic genClk;
  logic genRise;
  logic inRise;
  logic outRise;
  logic srcRise;
  logic fsResync;
  logic [3:0] stbCnt;
  logic genStrobe;
  logic genStart;
  logic [3:0] wordCnt;
  logic fsGen;
  logic inStart;
  logic outStart;
  logic [15:0] inShift;
  logic [15:0] next_inShift;
  logic [4:0] inCnt;
  logic inRun;
  logic pushValid;
  logic pushReady;
  logic [15:0] pushData;
  logic [15:0] holdBuf;
  logic holdFull;
  localparam int LOAD_DELAY_W = pcmsp_pkg::LOAD_DELAY;
  logic [LOAD_DELAY_W-1:0] oldPipe;
  logic load;
  logic [15:0] outShift;
  logic [4:0] txCnt;
  logic [7:0] addrShift;
  logic [3:0] addrCnt;
  pcmsp_pkg::pcmsp_tx_t txState;
  logic outEnable;

  // Pin inputs pass two flip-flops; a third stage keeps the previous level for edges.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pinA <= 7'h00;
      pinB <= 7'h00;
      pinP <= 7'h00;
    end
    else
    begin
      pinA <= {outEnableNIn, frameSyncIn, outStrobeIn, inStrobeIn, outBitClockIn, inBitClockIn, serialDataIn};
      pinB <= pinA;
      pinP <= pinB;
    end
  end

  pcmsp_clkdiv u_clkdiv (
    .mclk(mclk),
    .rst_n(rst_n),
    .rateSel(clkRateSelect),
    .clkLevel(genClk),
    .risePulse(genRise)
  );

  assign inRise = inClkActive ? genRise : (pinB[P_ICK] && !pinP[P_ICK]);
  assign outRise = outClkActive ? genRise : (pinB[P_OCK] && !pinP[P_OCK]);
  assign srcRise = strobeSourceSel ? outRise : inRise;
  assign fsResync = !syncOutEnable && pinP[P_FS] && !pinB[P_FS];
  assign inStart = inStrobeActive ? genStart : (pinP[P_ILD] && !pinB[P_ILD]);
  assign outStart = outStrobeActive ? genStart : (pinP[P_OLD] && !pinB[P_OLD]);
  assign fsGen = syncRateSelect ? wordCnt[pcmsp_pkg::FS_BIT_DIV16] : wordCnt[pcmsp_pkg::FS_BIT_DIV8];

  // Common strobe generator: low for one bit out of sixteen; frame sync restarts it.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stbCnt <= 4'h0;
      genStrobe <= 1'b1;
      genStart <= 1'b0;
    end
    else if (fsResync)
    begin
      stbCnt <= 4'h0;
      genStrobe <= 1'b0;
      genStart <= 1'b1;
    end
    else if (srcRise)
    begin
      stbCnt <= stbCnt + 4'h1;
      genStrobe <= stbCnt != pcmsp_pkg::STROBE_LAST;
      genStart <= stbCnt == pcmsp_pkg::STROBE_LAST;
    end
    else
      genStart <= 1'b0;
  end

  // Word counter behind the driven frame sync.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      wordCnt <= 4'h0;
    else if (genStart)
      wordCnt <= wordCnt + 4'h1;
  end

  always_comb
  begin
    if (bitOrderSelect)
      next_inShift = {inShift[14:0], pinB[P_DI]};
    else
      next_inShift = {pinB[P_DI], inShift[15:1]};
  end

  // Input word assembly.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      inShift <= 16'h0000;
      inCnt <= 5'h00;
      inRun <= 1'b0;
      pushValid <= 1'b0;
      pushData <= 16'h0000;
      inWordDropped <= 1'b0;
    end
    else
    begin
      pushValid <= 1'b0;
      inWordDropped <= 1'b0;
      if (inStart)
      begin
        inRun <= 1'b1;
        inCnt <= 5'h00;
      end
      else if (inRise && inRun)
      begin
        inShift <= next_inShift;
        inCnt <= inCnt + 5'h01;
        if (inCnt == (inLenSelect ? pcmsp_pkg::LEN_SHORT : pcmsp_pkg::LEN_LONG) - 5'h01)
        begin
          inRun <= 1'b0;
          pushValid <= pushReady;
          inWordDropped <= !pushReady;
          pushData <= next_inShift;
        end
      end
    end
  end

  pcmsp_buf2 u_inbuf (
    .mclk(mclk),
    .rst_n(rst_n),
    .inData(pushData),
    .inValid(pushValid),
    .inReady(pushReady),
    .outData(inWordData),
    .outValid(inputBufferFullFlag),
    .outReady(inWordRead)
  );

  assign load = oldPipe[LOAD_DELAY_W-1] && holdFull;

  // Output holding buffer written by software.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      holdBuf <= 16'h0000;
      holdFull <= 1'b0;
      outWordReady <= 1'b1;
      oldPipe <= '0;
    end
    else
    begin
      oldPipe <= {oldPipe[LOAD_DELAY_W-2:0], outStart};
      if (load)
      begin
        holdFull <= 1'b0;
        outWordReady <= 1'b1;
      end
      else if (outWordValid && outWordReady)
      begin
        holdBuf <= outWordData;
        holdFull <= 1'b1;
        outWordReady <= 1'b0;
      end
    end
  end

  // Output shifter, address stream and empty flag.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      outShift <= 16'h0000;
      txCnt <= 5'h00;
      addrShift <= 8'h00;
      addrCnt <= 4'h0;
      txState <= pcmsp_pkg::TX_IDLE;
      outputShifterEmpty <= pcmsp_pkg::EMPTY_RESET;
      serialDataOut <= 1'b0;
      serialAddrOut <= 1'b1;
    end
    else if (load)
    begin
      outShift <= holdBuf;
      txCnt <= outLenSelect ? pcmsp_pkg::LEN_SHORT : pcmsp_pkg::LEN_LONG;
      addrShift <= serialAddrWord;
      addrCnt <= pcmsp_pkg::ADDR_BITS;
      txState <= pcmsp_pkg::TX_SHIFT;
      outputShifterEmpty <= 1'b0;
    end
    else if (outRise)
    begin
      case (txState)
        pcmsp_pkg::TX_SHIFT:
        begin
          if (txCnt != 5'h00)
          begin
            serialDataOut <= bitOrderSelect ? outShift[15] : outShift[0];
            outShift <= bitOrderSelect ? {outShift[14:0], 1'b0} : {1'b0, outShift[15:1]};
            txCnt <= txCnt - 5'h01;
            serialAddrOut <= (addrCnt != 4'h0) ? ~addrShift[7] : 1'b1;
            addrShift <= {addrShift[6:0], 1'b0};
            if (addrCnt != 4'h0)
              addrCnt <= addrCnt - 4'h1;
          end
          else
          begin
            txState <= pcmsp_pkg::TX_IDLE;
            outputShifterEmpty <= 1'b1;
            serialAddrOut <= 1'b1;
          end
        end
        default:
          txState <= pcmsp_pkg::TX_IDLE;
      endcase
    end
  end

  assign outEnable = multiprocMode ? slotActive : !pinB[P_OUTPUT_ENABLE_N];

  // Pin drive levels and directions.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      inBitClockOut <= 1'b0;
      inBitClockOe <= 1'b0;
      outBitClockOut <= 1'b0;
      outBitClockOe <= 1'b0;
      inStrobeOut <= 1'b1;
      inStrobeOe <= 1'b0;
      outStrobeOut <= 1'b1;
      outStrobeOe <= 1'b0;
      serialDataOutOe <= 1'b0;
      serialAddrOe <= 1'b0;
      outEnableNOut <= 1'b1;
      outEnableNOe <= 1'b0;
      frameSyncOut <= 1'b0;
      frameSyncOe <= 1'b0;
    end
    else
    begin
      inBitClockOut <= genClk;
      inBitClockOe <= inClkActive;
      outBitClockOut <= genClk;
      outBitClockOe <= outClkActive;
      inStrobeOut <= genStrobe;
      inStrobeOe <= inStrobeActive;
      outStrobeOut <= genStrobe;
      outStrobeOe <= outStrobeActive;
      serialDataOutOe <= outEnable;
      serialAddrOe <= outEnable;
      outEnableNOut <= !slotActive;
      outEnableNOe <= multiprocMode;
      frameSyncOut <= fsGen;
      frameSyncOe <= syncOutEnable;
    end
  end

  default clocking cb @(posedge mclk); endclocking

  chk_empty_reset: assert property (!rst_n |=> outputShifterEmpty) else $error("empty flag low after reset");
  chk_full_reset: assert property (!rst_n |=> !inputBufferFullFlag) else $error("full flag high after reset");
  chk_empty_clear: assert property (disable iff (!rst_n)
    outStart && holdFull && !outWordReady ##2 holdFull |=> !outputShifterEmpty)
    else $error("empty flag not cleared two cycles after strobe");
  chk_empty_hold: assert property (disable iff (!rst_n)
    oldPipe[LOAD_DELAY_W-1] && !holdFull && outputShifterEmpty |=> outputShifterEmpty)
    else $error("empty flag cleared without a new word");
  chk_data_release: assert property (disable iff (!rst_n)
    !multiprocMode && pinB[P_OUTPUT_ENABLE_N] |=> !serialDataOutOe && !serialAddrOe)
    else $error("data driven while enable high");
  chk_slot_drive: assert property (disable iff (!rst_n)
    multiprocMode && !slotActive |=> outEnableNOe && outEnableNOut && !serialAddrOe)
    else $error("drive outside own slot");
  chk_sync_dir: assert property (disable iff (!rst_n) 1'b1 |=> frameSyncOe == $past(syncOutEnable))
    else $error("frame sync direction wrong");
  chk_clock_dir: assert property (disable iff (!rst_n) 1'b1 |=> inBitClockOe == $past(inClkActive))
    else $error("input clock direction wrong");
  chk_word_push: assert property (disable iff (!rst_n)
    pushValid |=> inputBufferFullFlag)
    else $error("pushed word not flagged");
  chk_full_read: assert property (disable iff (!rst_n)
    inputBufferFullFlag && inWordRead && !pushValid && !$past(pushValid) ##0 u_inbuf.count == 2'h1
    |=> !inputBufferFullFlag) else $error("full flag not negated by read");

  cov_load: cover property (disable iff (!rst_n) $fell(outputShifterEmpty));
  cov_full: cover property (disable iff (!rst_n) $rose(inputBufferFullFlag));
  cov_resync: cover property (disable iff (!rst_n) fsResync);
  cov_empty: cover property (disable iff (!rst_n) $rose(outputShifterEmpty));
endmodule : pcmsp_port
`default_nettype wire

// ### bench/pcmsp_codec.sv
// Codec model that clocks framed words into and out of the serial port.
`timescale 1ns/1ps
`default_nettype none
module pcmsp_codec #(
  parameter int HALF = 10
) (
  // Clock.
  input wire logic mclk,
  // Pins driven by the codec.
  output logic bitClk,
  output logic strobe,
  output logic dataToPort,
  // Pins sampled by the codec.
  input wire logic dataFromPort,
  input wire logic addrFromPort
);
  initial
  begin
    bitClk = 1'b0;
    strobe = 1'b1;
    dataToPort = 1'b0;
  end
  // Runs one frame; bit i of each vector is the i-th bit on the wire.
  task automatic frame(input logic [15:0] txBits, input int n, output logic [15:0] rxBits, output logic [7:0] rxAddr);
    rxBits = 16'h0000;
    rxAddr = 8'h00;
    @(negedge mclk);
    strobe = 1'b0;
    dataToPort = txBits[0];
    for (int i = 0; i <= n; i++)
    begin
      repeat (HALF) @(negedge mclk);
      bitClk = 1'b1;
      repeat (HALF) @(negedge mclk);
      bitClk = 1'b0;
      strobe = 1'b1;
      if (i < n)
        rxBits[i] = dataFromPort;
      if (i < 8)
        rxAddr[i] = addrFromPort;
      dataToPort = (i + 1 < n) ? txBits[i + 1] : ~dataToPort;
    end
  endtask : frame
endmodule : pcmsp_codec
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the serial PCM port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic bitOrderSelect = 1'b1;
  logic inLenSelect = 1'b0;
  logic outLenSelect = 1'b0;
  logic inClkActive = 1'b0;
  logic outClkActive = 1'b0;
  logic inStrobeActive = 1'b0;
  logic outStrobeActive = 1'b0;
  logic strobeSourceSel = 1'b0;
  logic [1:0] clkRateSelect = 2'h0;
  logic multiprocMode = 1'b0;
  logic slotActive = 1'b0;
  logic syncOutEnable = 1'b0;
  logic syncRateSelect = 1'b0;
  logic [7:0] serialAddrWord = 8'h00;
  logic [15:0] outWordData = 16'h0000;
  logic outWordValid = 1'b0;
  logic inWordRead = 1'b0;
  logic outEnableNIn = 1'b0;
  logic frameSyncIn = 1'b0;
  logic outWordReady, inputBufferFullFlag, outputShifterEmpty, inWordDropped;
  logic [15:0] inWordData;
  logic inBitClockOut, inBitClockOe, inStrobeOut, inStrobeOe, outBitClockOut, outBitClockOe;
  logic outStrobeOut, outStrobeOe, serialDataOut, serialDataOutOe, outEnableNOut, outEnableNOe;
  logic serialAddrOut, serialAddrOe, frameSyncOut, frameSyncOe;
  logic cdClk, cdStrobe, serialDataIn;
  wire logic inBitClockIn = inBitClockOe ? inBitClockOut : cdClk;
  wire logic outBitClockIn = outBitClockOe ? outBitClockOut : cdClk;
  wire logic inStrobeIn = inStrobeOe ? inStrobeOut : cdStrobe;
  wire logic outStrobeIn = outStrobeOe ? outStrobeOut : cdStrobe;
  wire logic dataLine = serialDataOutOe ? serialDataOut : 1'bz;
  wire logic serialAddrIn = serialAddrOe ? serialAddrOut : 1'bz;
  int failCount = 0;
  int comparisons = 0;
  int dropCount = 0;
  int seed, per, curLen;
  logic [31:0] rnd;
  logic [15:0] rx, txw, w1, w2;
  logic [7:0] rxA;
  int divs[4] = '{4, 12, 16, 20};

  always #20 mclk = ~mclk;
  always @(posedge mclk)
    if (inWordDropped === 1'b1)
      dropCount++;

  pcmsp_port uut (.mclk, .rst_n, .bitOrderSelect, .inLenSelect, .outLenSelect, .inClkActive, .outClkActive,
    .inStrobeActive, .outStrobeActive, .strobeSourceSel, .clkRateSelect, .multiprocMode, .slotActive,
    .syncOutEnable, .syncRateSelect, .serialAddrWord, .outWordData, .outWordValid, .outWordReady, .inWordData,
    .inputBufferFullFlag, .inWordRead, .outputShifterEmpty, .inWordDropped, .serialDataIn, .inBitClockIn,
    .inBitClockOut, .inBitClockOe, .inStrobeIn, .inStrobeOut, .inStrobeOe, .outBitClockIn, .outBitClockOut,
    .outBitClockOe, .outStrobeIn, .outStrobeOut, .outStrobeOe, .serialDataOut, .serialDataOutOe, .outEnableNIn,
    .outEnableNOut, .outEnableNOe, .serialAddrIn, .serialAddrOut, .serialAddrOe, .frameSyncIn, .frameSyncOut,
    .frameSyncOe);
  pcmsp_codec #(.HALF(10)) codec (.mclk, .bitClk(cdClk), .strobe(cdStrobe), .dataToPort(serialDataIn),
    .dataFromPort(dataLine), .addrFromPort(serialAddrIn));

  task automatic testDone;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : testDone
  task automatic checkBit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      failCount++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : checkBit
  task automatic checkWord(input string what, input logic [15:0] exp, input logic [15:0] got, input logic [15:0] m);
    comparisons++;
    if ((got & m) !== (exp & m))
    begin
      failCount++;
      $display("unexpected %s expected %h seen %h", what, exp & m, got & m);
    end
  endtask : checkWord
  task automatic checkCount(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp)
    begin
      failCount++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask : checkCount
  function automatic logic [15:0] wireOf(input logic [15:0] w, input logic msb);
    logic [15:0] v;
    for (int i = 0; i < 16; i++)
      v[i] = msb ? w[15 - i] : w[i];
    return v;
  endfunction : wireOf
  function automatic logic [15:0] inExpect(input logic [15:0] bits, input int n, input logic msb);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < n; i++)
      if (msb)
        v[n - 1 - i] = bits[i];
      else
        v[16 - n + i] = bits[i];
    return v;
  endfunction : inExpect
  function automatic logic [15:0] inMask(input int n, input logic msb);
    return (n == 16) ? 16'hFFFF : (msb ? 16'h00FF : 16'hFF00);
  endfunction : inMask
  task automatic waitCycles(input int n);
    repeat (n) @(negedge mclk);
  endtask : waitCycles
  task automatic writeWord(input logic [15:0] w);
    int n;
    outWordData = w;
    outWordValid = 1'b1;
    for (n = 0; n < 50 && outWordReady !== 1'b1; n++)
      @(negedge mclk);
    if (n == 50)
    begin
      failCount++;
      $display("unexpected timeout waiting for write ready");
      testDone();
    end
    @(negedge mclk);
    outWordValid = 1'b0;
    checkBit("write ready after take", 1'b0, outWordReady);
  endtask : writeWord
  task automatic doFrame(input logic [15:0] inw, input logic emptyMid);
    fork
      codec.frame(inw, curLen, rx, rxA);
      begin
        waitCycles(14);
        checkBit("shifter empty in frame", emptyMid, outputShifterEmpty);
      end
    join
    waitCycles(8);
    checkBit("shifter empty after frame", 1'b1, outputShifterEmpty);
    checkBit("full flag after frame", 1'b1, inputBufferFullFlag);
  endtask : doFrame
  task automatic readWord(input logic [15:0] exp, input logic lastOne);
    checkWord("input word", exp, inWordData, inMask(curLen, bitOrderSelect));
    inWordRead = 1'b1;
    @(negedge mclk);
    inWordRead = 1'b0;
    waitCycles(2);
    checkBit("full flag after read", ~lastOne, inputBufferFullFlag);
  endtask : readWord
  task automatic measure(input int which);
    logic prev, cur;
    int n, falls;
    per = 0;
    falls = 0;
    prev = 1'b0;
    for (n = 0; n < 4000 && falls < 2; n++)
    begin
      @(negedge mclk);
      case (which)
        0: cur = inBitClockOut;
        1: cur = inStrobeOut;
        2: cur = outStrobeOut;
        4: cur = outBitClockOut;
        default: cur = frameSyncOut;
      endcase
      if (falls == 1)
        per++;
      if (prev === 1'b1 && cur === 1'b0)
        falls++;
      prev = cur;
    end
    if (falls < 2)
    begin
      failCount++;
      $display("unexpected timeout waiting for pin edges");
      testDone();
    end
  endtask : measure

  initial
  begin
    seed = 39871;
    waitCycles(6);
    rst_n = 1'b1;
    @(negedge mclk);
    checkBit("shifter empty after reset", 1'b1, outputShifterEmpty);
    checkBit("full flag after reset", 1'b0, inputBufferFullFlag);
    checkBit("passive input clock", 1'b0, inBitClockOe);
    for (int k = 0; k < 8; k++)
    begin
      rnd = $random(seed);
      bitOrderSelect = (k < 4) ? k[0] : rnd[0];
      inLenSelect = (k < 4) ? k[1] : rnd[1];
      outLenSelect = inLenSelect;
      curLen = inLenSelect ? 8 : 16;
      serialAddrWord = rnd[15:8];
      txw = rnd[31:16];
      rnd = $random(seed);
      writeWord(txw);
      doFrame(rnd[15:0], 1'b0);
      checkWord("serial output", wireOf(txw, bitOrderSelect), rx, (curLen == 16) ? 16'hFFFF : 16'h00FF);
      checkWord("address stream", ~wireOf({serialAddrWord, 8'h00}, 1'b1), {8'h00, rxA}, 16'h00FF);
      readWord(inExpect(rnd[15:0], curLen, bitOrderSelect), 1'b1);
    end
    bitOrderSelect = 1'b1;
    inLenSelect = 1'b0;
    outLenSelect = 1'b0;
    curLen = 16;
    writeWord(16'hA5C3);
    @(negedge mclk);
    outWordData = 16'h0F0F;
    outWordValid = 1'b1;
    @(negedge mclk);
    outWordValid = 1'b0;
    doFrame(16'h1234, 1'b0);
    checkWord("output after refused write", 16'hA5C3, wireOf(rx, 1'b1), 16'hFFFF);
    readWord(inExpect(16'h1234, 16, 1'b1), 1'b1);
    w1 = 16'h8001;
    w2 = 16'h7FFE;
    doFrame(w1, 1'b1);
    doFrame(w2, 1'b1);
    doFrame(16'h5555, 1'b1);
    checkCount("dropped words", 1, dropCount);
    readWord(w1, 1'b0);
    readWord(w2, 1'b1);
    writeWord(16'hFFFF);
    fork
      codec.frame(16'hC0DE, 16, rx, rxA);
      begin
        waitCycles(30);
        rst_n = 1'b0;
        waitCycles(2);
        rst_n = 1'b1;
        @(negedge mclk);
        checkBit("shifter empty after reset", 1'b1, outputShifterEmpty);
        checkBit("full flag after reset", 1'b0, inputBufferFullFlag);
      end
    join
    for (int k = 0; k < 6; k++)
    begin
      rnd = $random(seed);
      outEnableNIn = rnd[0];
      waitCycles(5);
      checkBit("data output enable", ~outEnableNIn, serialDataOutOe);
      checkBit("address output enable", ~outEnableNIn, serialAddrOe);
      checkBit("enable pin direction", 1'b0, outEnableNOe);
    end
    multiprocMode = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      rnd = $random(seed);
      slotActive = rnd[0];
      waitCycles(5);
      checkBit("enable pin driven", 1'b1, outEnableNOe);
      checkBit("slot enable level", ~slotActive, outEnableNOut);
      checkBit("address in own slot", slotActive, serialAddrOe);
      checkBit("data in own slot", slotActive, serialDataOutOe);
    end
    multiprocMode = 1'b0;
    inClkActive = 1'b1;
    outClkActive = 1'b1;
    inStrobeActive = 1'b1;
    outStrobeActive = 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      clkRateSelect = r[1:0];
      waitCycles(40);
      measure(0);
      checkCount("bit clock period", divs[r], per);
      measure(4);
      checkCount("output clock period", divs[r], per);
    end
    checkBit("input clock driven", 1'b1, inBitClockOe);
    checkBit("output clock driven", 1'b1, outBitClockOe);
    checkBit("input strobe driven", 1'b1, inStrobeOe);
    checkBit("output strobe driven", 1'b1, outStrobeOe);
    clkRateSelect = 2'h0;
    for (int s = 0; s < 2; s++)
    begin
      strobeSourceSel = s[0];
      waitCycles(80);
      measure(1);
      checkCount("input strobe period", 64, per);
      measure(2);
      checkCount("output strobe period", 64, per);
    end
    syncOutEnable = 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      syncRateSelect = s[0];
      measure(3);
      measure(3);
      checkCount("frame sync period", s ? 1024 : 512, per);
      checkBit("frame sync driven", 1'b1, frameSyncOe);
    end
    syncOutEnable = 1'b0;
    waitCycles(4);
    checkBit("frame sync released", 1'b0, frameSyncOe);
    frameSyncIn = 1'b1;
    waitCycles(4);
    frameSyncIn = 1'b0;
    waitCycles(4);
    checkBit("input strobe after frame sync", 1'b0, inStrobeOut);
    waitCycles(64);
    checkBit("output strobe one word after sync", 1'b0, outStrobeOut);
    frameSyncIn = 1'b0;
    testDone();
  end
endmodule : testbench
`default_nettype wire
